/* File: hdl/adc_port_pkg.sv */
package adc_port_pkg;

    // ----
    // Register map (byte addresses, one 32-bit word each)
    // ----
    localparam logic [3:0] REG_CTRL = 4'h0;    // Conversion start strobe
    localparam logic [3:0] REG_RESULT = 4'h4;  // Result word, write ends a conversion
    localparam logic [3:0] REG_STATUS = 4'h8;  // Read-only port state

    // CTRL fields
    localparam int CTRL_START_BIT = 0;

    // STATUS fields
    localparam int ST_SERIAL_BIT = 0;
    localparam int ST_SLAVE_BIT = 1;
    localparam int ST_FRAME_BIT = 2;
    localparam int ST_CONV_BIT = 3;
    localparam int ST_MODE_LO = 4;
    localparam int ST_DIV_LO = 6;
    localparam int ST_RD_CONV_BIT = 8;

    // ----
    // Data bus pin roles in serial modes
    // ----
    localparam int PIN_DIV_LO = 2;       // Divider select, low bit
    localparam int PIN_DIV_HI = 3;       // Divider select, high bit
    localparam int PIN_CLK_SRC = 4;      // Clock source select
    localparam int PIN_SYNC_POL = 5;     // Sync polarity select
    localparam int PIN_EDGE_INV = 6;     // Clock edge invert
    localparam int PIN_RD_CONV = 7;      // Read during convert / daisy chain in
    localparam int PIN_SER_OUT = 8;      // Serial data out
    localparam int PIN_SER_CLK = 9;      // Serial data clock

    // Output enables per mode
    localparam logic [15:0] OE_PARALLEL = 16'hFFFF;
    localparam logic [15:0] OE_SERIAL = 16'h0103;
    localparam logic [15:0] OE_SER_CLK = 16'h0200;

    // Reset values
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

    // Conversion mode codes
    localparam logic [1:0] CONV_NORMAL = 2'h0;
    localparam logic [1:0] CONV_IMPULSE = 2'h1;
    localparam logic [1:0] CONV_WARP = 2'h2;

    // Master clock: system cycles per half period before division
    localparam int SCLK_BASE_HALF = 2;

endpackage

/* File: hdl/shift_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Load and step commands to the result shift register, bit back
interface shift_link_if #(parameter int DATA_W = 16) ();
    logic load;                 // Capture word, present its MSB
    logic step;                 // Advance to next bit
    logic chain_in;             // Bit entering at the LSB end
    logic [DATA_W-1:0] word;    // Word to capture
    logic sdo;                  // Bit now presented
    logic last;                 // LSB is now presented

    modport shifter (input load, input step, input chain_in, input word,
                     output sdo, output last);
    modport ctrl (output load, output step, output chain_in, output word,
                  input sdo, input last);
endinterface
`default_nettype wire

/* File: hdl/result_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
module result_shifter #(
    parameter int DATA_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    shift_link_if.shifter link
);
    localparam int CW = $clog2(DATA_W);
    localparam logic [CW-1:0] CNT_LAST = CW'(DATA_W - 1);

    logic [DATA_W-1:0] sreg, next_sreg;  // Remaining bits, MSB presented
    logic [CW-1:0] cnt, next_cnt;        // Bits already stepped past

    // ----
    // Next state
    // ----
    always_comb begin
        next_sreg = sreg;
        next_cnt = cnt;
        if (link.load) begin
            // Fresh word, MSB first
            next_sreg = link.word;
            next_cnt = '0;
        end else if (link.step && cnt != CNT_LAST) begin
            // Daisy chain bit fills from the bottom
            next_sreg = {sreg[DATA_W-2:0], link.chain_in};
            next_cnt = cnt + CW'(1);
        end
    end

    // Registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sreg <= '0;
            cnt <= '0;
        end else begin
            sreg <= next_sreg;
            cnt <= next_cnt;
        end
    end

    assign link.sdo = sreg[DATA_W-1];
    assign link.last = (cnt == CNT_LAST);
endmodule
`default_nettype wire

/* File: hdl/serial_clock_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_clock_gen #(
    parameter int BASE_HALF = 2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [1:0] div_i,
    input wire logic idle_level_i,
    output logic sclk_o,
    output logic lead_o,
    output logic trail_o
);
    logic [7:0] cnt, next_cnt;    // Cycles into the half period
    logic [7:0] half;             // Half period length
    logic next_sclk, next_lead, next_trail;

    // Elaboration check on the base rate
    if (BASE_HALF < 2 || BASE_HALF > 32) begin : g_chk
        $error("BASE_HALF must lie in 2..32");
    end

    // Divider doubles the half period per step
    assign half = 8'(BASE_HALF) << div_i;

    // ----
    // Clock toggling
    // ----
    always_comb begin
        next_cnt = cnt + 8'h01;
        next_sclk = sclk_o;
        next_lead = 1'b0;
        next_trail = 1'b0;
        if (!run_i) begin
            // Parked at idle level between frames
            next_cnt = 8'h00;
            next_sclk = idle_level_i;
        end else if (cnt == half - 8'h01) begin
            next_cnt = 8'h00;
            next_sclk = ~sclk_o;
            next_lead = (sclk_o == idle_level_i);
            next_trail = (sclk_o != idle_level_i);
        end
    end

    // Registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt <= 8'h00;
            sclk_o <= 1'b0;
            lead_o <= 1'b0;
            trail_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            sclk_o <= next_sclk;
            lead_o <= next_lead;
            trail_o <= next_trail;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/adc_result_port.sv */
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Select low parallel; high serial, rest floating
// - Data bits 0 and 1 driven in every mode out of reset
// - Parallel mode drives result bits 2, 3
// - Divider pins slow master read-after-convert clock
// - Other serial modes float, ignore divider pins
// - Parallel mode drives result bits 4 to 7
// - Clock source low: master, clock driven out
// - Clock source high: slave on gated clock
// - Sync active high unless polarity select high
// - Edge invert picks rising or falling edges
// - Read timing: after or during conversion
// - Two mode inputs pick normal, impulse, warp
// - Slave updates data on selected clock edge
module adc_result_port #(
    parameter int DATA_W = 16,
    parameter int SCLK_HALF = adc_port_pkg::SCLK_BASE_HALF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [3:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [3:0] byteenable_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // Straps and control pins
    input wire logic serial_parallel_select_i,
    input wire logic low_power_mode_i,
    input wire logic fast_mode_i,
    input wire logic cs_n_i,
    // Data bus pins, split three ways
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] data_o,
    output logic [DATA_W-1:0] data_oe_o,
    // Frame sync and conversion mode
    output logic sync_o,
    output logic [1:0] conv_mode_o
);
    // ----
    // Elaboration check
    // ----
    if (DATA_W != 16) begin : g_chk
        $error("Pin roles fix DATA_W at 16");
    end

    // ----
    // Declarations
    // ----
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FRAME = 2'b10
    } frame_state_t;

    frame_state_t state, next_state;        // Master frame sequencer
    logic [DATA_W-1:0] result, next_result; // Last finished conversion
    logic converting, next_converting;      // Conversion in progress
    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic [DATA_W-1:0] next_data, next_oe;
    logic next_sync;
    logic [1:0] next_conv_mode;
    logic ser_clk_prev;                     // Previous slave clock sample
    logic cs_prev;                          // Previous chip select sample
    logic [31:0] wmask;                     // Byte lane mask
    logic taken;                            // Bus request accepted now
    logic wr_ctrl, wr_result;               // Accepted register writes
    logic serial, slave, edge_inv, sync_pol, rd_conv;
    logic [1:0] div_eff;                    // Divider actually applied
    logic run;                              // Master clock running
    logic sclk, lead, trail;                // Generated clock and its edges
    logic slave_edge;                       // Active edge of host clock
    logic cs_fall;                          // Chip select just asserted
    logic start_frame;                      // Master frame trigger

    shift_link_if #(.DATA_W(DATA_W)) link ();

    // ----
    // Strap decode
    // ----
    // serial select
    assign serial = serial_parallel_select_i;
    assign slave = serial && data_i[adc_port_pkg::PIN_CLK_SRC];
    assign edge_inv = serial && data_i[adc_port_pkg::PIN_EDGE_INV];
    assign sync_pol = data_i[adc_port_pkg::PIN_SYNC_POL];
    assign rd_conv = data_i[adc_port_pkg::PIN_RD_CONV];

    always_comb begin
        div_eff = 2'h0;
        if (serial && !slave && !rd_conv) begin
            div_eff = {data_i[adc_port_pkg::PIN_DIV_HI], data_i[adc_port_pkg::PIN_DIV_LO]};
        end
    end

    // ----
    // Bus decode
    // ----
    // Accepted on the edge where waitrequest is low
    assign taken = (read_i || write_i) && !waitrequest_o;
    assign wmask = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                    {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
    assign wr_ctrl = taken && write_i && address_i == adc_port_pkg::REG_CTRL
                     && byteenable_i[0] && writedata_i[adc_port_pkg::CTRL_START_BIT];
    assign wr_result = taken && write_i && address_i == adc_port_pkg::REG_RESULT;

    // ----
    // Serial event detection
    // ----
    assign cs_fall = cs_prev && !cs_n_i;
    assign slave_edge = slave && !cs_n_i
                        && (edge_inv ? (ser_clk_prev && !data_i[adc_port_pkg::PIN_SER_CLK])
                                     : (!ser_clk_prev && data_i[adc_port_pkg::PIN_SER_CLK]));

    assign start_frame = serial && !slave && state == ST_IDLE
                         && (rd_conv ? wr_ctrl : wr_result);

    // ----
    // Shifter control
    // ----
    always_comb begin
        link.load = 1'b0;
        link.step = 1'b0;
        link.word = result;
        link.chain_in = rd_conv;
        if (slave) begin
            link.load = cs_fall;
            link.step = slave_edge;
        end else begin
            // Master: load at frame start, step on trailing edges
            link.load = start_frame;
            link.step = (state == ST_FRAME) && trail;
            // Read after convert shifts the word just written
            if (!rd_conv && wr_result) begin
                link.word = writedata_i[DATA_W-1:0];
            end
        end
    end

    result_shifter #(.DATA_W(DATA_W)) u_shift (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .link(link)
    );

    serial_clock_gen #(.BASE_HALF(SCLK_HALF)) u_clk (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(run),
        .div_i(div_eff),
        .idle_level_i(edge_inv),
        .sclk_o(sclk),
        .lead_o(lead),
        .trail_o(trail)
    );

    assign run = (state == ST_FRAME);

    // ----
    // Frame sequencer and conversion flag
    // ----
    always_comb begin
        next_state = state;
        next_converting = converting;
        next_result = result;
        unique case (state)
            ST_IDLE: begin
                if (start_frame) begin
                    next_state = ST_FRAME;
                end
            end
            ST_FRAME: begin
                // Ends on the trailing edge after the LSB
                if (trail && link.last) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (wr_ctrl) begin
            next_converting = 1'b1;
        end
        if (wr_result) begin
            next_converting = 1'b0;
            next_result = (writedata_i[DATA_W-1:0] & wmask[DATA_W-1:0])
                          | (result & ~wmask[DATA_W-1:0]);
        end
    end

    // ----
    // Bus answers
    // ----
    always_comb begin
        next_readdata = readdata_o;
        // One wait cycle per request, then back to waiting
        next_waitrequest = !((read_i || write_i) && waitrequest_o);
        if ((read_i || write_i) && waitrequest_o) begin
            next_readdata = adc_port_pkg::RDATA_NONE;
            if (read_i) begin
                unique case (address_i)
                    adc_port_pkg::REG_RESULT: begin
                        next_readdata[DATA_W-1:0] = result;
                    end
                    adc_port_pkg::REG_STATUS: begin
                        next_readdata[adc_port_pkg::ST_SERIAL_BIT] = serial;
                        next_readdata[adc_port_pkg::ST_SLAVE_BIT] = slave;
                        next_readdata[adc_port_pkg::ST_FRAME_BIT] = run;
                        next_readdata[adc_port_pkg::ST_CONV_BIT] = converting;
                        next_readdata[adc_port_pkg::ST_MODE_LO +: 2] = conv_mode_o;
                        next_readdata[adc_port_pkg::ST_DIV_LO +: 2] = div_eff;
                        next_readdata[adc_port_pkg::ST_RD_CONV_BIT] = serial && rd_conv;
                    end
                    // Control and unmapped words read zero
                    default: next_readdata = adc_port_pkg::RDATA_NONE;
                endcase
            end
        end
    end

    // ----
    // Pin drive
    // ----
    always_comb begin
        next_data = result;
        next_oe = adc_port_pkg::OE_PARALLEL;
        next_sync = 1'b0;
        if (serial) begin
            next_oe = adc_port_pkg::OE_SERIAL;
            next_data[adc_port_pkg::PIN_SER_OUT] = link.sdo;
            if (!slave) begin
                next_oe = adc_port_pkg::OE_SERIAL | adc_port_pkg::OE_SER_CLK;
                next_data[adc_port_pkg::PIN_SER_CLK] = sclk;
                next_sync = run ^ sync_pol;
            end
        end
        unique case ({fast_mode_i, low_power_mode_i})
            2'b01: next_conv_mode = adc_port_pkg::CONV_IMPULSE;
            2'b10: next_conv_mode = adc_port_pkg::CONV_WARP;
            default: next_conv_mode = adc_port_pkg::CONV_NORMAL;
        endcase
    end

    // ----
    // Registers
    // ----
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            result <= adc_port_pkg::RESULT_RST;
            converting <= 1'b0;
            readdata_o <= adc_port_pkg::RDATA_NONE;
            waitrequest_o <= 1'b1;
            data_o <= '0;
            data_oe_o <= '0;
            sync_o <= 1'b0;
            conv_mode_o <= adc_port_pkg::CONV_NORMAL;
            ser_clk_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            state <= next_state;
            result <= next_result;
            converting <= next_converting;
            readdata_o <= next_readdata;
            waitrequest_o <= next_waitrequest;
            data_o <= next_data;
            data_oe_o <= next_oe;
            sync_o <= next_sync;
            conv_mode_o <= next_conv_mode;
            ser_clk_prev <= data_i[adc_port_pkg::PIN_SER_CLK];
            cs_prev <= cs_n_i;
        end
    end
endmodule
`default_nettype wire

/* File: verification/adc_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Pin role and mode checks at the ports
// ----
module adc_port_chk #(
    parameter int DATA_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] address_i,
    input wire logic write_i,
    input wire logic [3:0] byteenable_i,
    input wire logic [31:0] writedata_i,
    input wire logic waitrequest_o,
    input wire logic serial_parallel_select_i,
    input wire logic low_power_mode_i,
    input wire logic fast_mode_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic [DATA_W-1:0] data_o,
    input wire logic [DATA_W-1:0] data_oe_o,
    input wire logic sync_o,
    input wire logic [1:0] conv_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [15:0] held; // Last full result word taken
    logic wr_res; // Result write taken this edge
    assign wr_res = write_i && !waitrequest_o && address_i == adc_port_pkg::REG_RESULT
        && byteenable_i[1:0] == 2'b11;
    // Keep the word for the parallel pin check
    always_ff @(posedge clk_i) begin
        if (wr_res) begin
            held <= writedata_i[15:0];
        end
    end
    property p_par_oe;
        $past(rst_n_i) && !$past(serial_parallel_select_i) |-> data_oe_o == 16'hFFFF;
    endproperty
    a_par_oe: assert property (p_par_oe)
        else $error("parallel enables wrong");
    property p_low_oe;
        $past(rst_n_i) |-> data_oe_o[1:0] == 2'b11;
    endproperty
    a_low_oe: assert property (p_low_oe)
        else $error("low pins not driven");
    property p_ser_float;
        $past(rst_n_i) && $past(serial_parallel_select_i)
            |-> data_oe_o[15:10] == 6'h00 && data_oe_o[7:2] == 6'h00;
    endproperty
    a_ser_float: assert property (p_ser_float)
        else $error("serial spare pins driven");
    property p_master_clk;
        $past(rst_n_i) && $past(serial_parallel_select_i) && !$past(data_i[4])
            |-> data_oe_o[9:8] == 2'b11;
    endproperty
    a_master_clk: assert property (p_master_clk)
        else $error("master clock pin not driven");
    property p_slave_clk;
        $past(rst_n_i) && $past(serial_parallel_select_i) && $past(data_i[4])
            |-> data_oe_o[9:8] == 2'b01;
    endproperty
    a_slave_clk: assert property (p_slave_clk)
        else $error("slave clock pin driven");
    property p_conv;
        $past(rst_n_i) |-> conv_mode_o == (($past(fast_mode_i) == $past(low_power_mode_i))
            ? adc_port_pkg::CONV_NORMAL : $past(fast_mode_i)
            ? adc_port_pkg::CONV_WARP : adc_port_pkg::CONV_IMPULSE);
    endproperty
    a_conv: assert property (p_conv)
        else $error("conversion mode wrong");
    property p_sync_off;
        $past(rst_n_i) && (!$past(serial_parallel_select_i) || $past(data_i[4])) |-> !sync_o;
    endproperty
    a_sync_off: assert property (p_sync_off)
        else $error("sync active outside master");
    property p_par_data;
        wr_res && !serial_parallel_select_i |-> ##[1:3] data_o == held;
    endproperty
    a_par_data: assert property (p_par_data)
        else $error("parallel word not on pins");
endmodule
bind adc_result_port adc_port_chk #(.DATA_W(DATA_W)) adc_port_chk_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .write_i(write_i),
    .byteenable_i(byteenable_i), .writedata_i(writedata_i), .waitrequest_o(waitrequest_o),
    .serial_parallel_select_i(serial_parallel_select_i), .low_power_mode_i(low_power_mode_i),
    .fast_mode_i(fast_mode_i), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .sync_o(sync_o), .conv_mode_o(conv_mode_o));
`default_nettype wire

/* File: verification/host_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Host reading results over the serial pins
// ----
module host_link_model (
    input wire logic clk_i,
    input wire logic [15:0] dev_data_i,
    input wire logic sync_i,
    output logic [15:0] host_drv_o,
    output logic [15:0] host_oe_o,
    output logic cs_n_o
);
    // Idle: nothing driven, deselected
    initial begin
        host_drv_o = 16'h0000;
        host_oe_o = 16'h0000;
        cs_n_o = 1'b1;
    end
    task straps(input logic [1:0] div, input logic div_on, input logic src,
        input logic pol, input logic inv, input logic rd_conv);
        @(posedge clk_i);
        host_drv_o[9:2] <= {inv, 1'b0, rd_conv, inv, pol, src, div};
        host_oe_o <= {6'h00, src, 1'b0, 4'hF, div_on, div_on, 2'b00};
    endtask
    // Take bits at each leading edge of the device clock
    task automatic master_read(input logic pol, input logic inv, output logic [15:0] w,
        output int per, output bit ok);
        int n = 0;
        logic prev;
        ok = 1'b1;
        w = 16'h0000;
        per = 0;
        while (sync_i !== ~pol && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        for (int b = 0; b < 16; b++) begin
            n = 0;
            do begin
                prev = dev_data_i[9];
                @(posedge clk_i);
                n++;
            end while (!(prev === inv && dev_data_i[9] === ~inv) && n < 200);
            w = {w[14:0], dev_data_i[8]};
            if (b == 1) begin
                per = n;
            end
            if (sync_i !== ~pol || n >= 200) begin
                ok = 1'b0;
            end
        end
    endtask
    // clock given only while selected
    // Sample after the active edge, before the other one
    task automatic slave_read(input logic inv, input int h, output logic [15:0] w);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        repeat (h) @(posedge clk_i);
        w = {15'h0000, dev_data_i[8]};
        for (int b = 1; b < 16; b++) begin
            host_drv_o[9] <= ~inv;
            repeat (h) @(posedge clk_i);
            w = {w[14:0], dev_data_i[8]};
            host_drv_o[9] <= inv;
            repeat (h) @(posedge clk_i);
        end
        cs_n_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ----
    // Stimulus and pins
    // ----
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] address_i = 4'h0;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [3:0] byteenable_i = 4'h0;
    logic [31:0] writedata_i = 32'h0;
    logic serial_parallel_select_i = 1'b0;
    logic low_power_mode_i = 1'b0;
    logic fast_mode_i = 1'b0;
    logic [31:0] readdata_o, rd;
    logic waitrequest_o, cs_n_i, sync_o;
    logic [1:0] conv_mode_o;
    logic [15:0] data_i, data_o, data_oe_o, host_drv, host_oe, w;
    logic [15:0] float_pat = 16'h5555; // Level of pins nobody drives
    logic [1:0] modes [4] = '{adc_port_pkg::CONV_NORMAL, adc_port_pkg::CONV_IMPULSE,
        adc_port_pkg::CONV_WARP, adc_port_pkg::CONV_NORMAL};
    logic [15:0] words [2] = '{16'hC35A, 16'h6B1E};
    int n_mismatch = 0;
    int n_tests = 0;
    int per;
    bit ok;
    // 40 MHz clock
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    // Floating pins change every cycle
    always @(posedge clk_i) begin
        float_pat <= ~float_pat;
    end
    // Wire level from both drivers
    assign data_i = (data_oe_o & data_o) | (~data_oe_o & host_oe & host_drv)
        | (~data_oe_o & ~host_oe & float_pat);
    adc_result_port adc_result_port_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .byteenable_i(byteenable_i), .writedata_i(writedata_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .serial_parallel_select_i(serial_parallel_select_i), .cs_n_i(cs_n_i),
        .low_power_mode_i(low_power_mode_i), .fast_mode_i(fast_mode_i), .data_i(data_i),
        .data_o(data_o), .data_oe_o(data_oe_o), .sync_o(sync_o), .conv_mode_o(conv_mode_o));
    host_link_model host_link_model_inst (
        .clk_i(clk_i), .dev_data_i(data_o), .sync_i(sync_o), .host_drv_o(host_drv),
        .host_oe_o(host_oe), .cs_n_o(cs_n_i));
    // ----
    // Tasks
    // ----
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task hung;
        n_mismatch++;
        $display("wrong value at %0t: no answer", $time);
        results();
    endtask
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n = 0;
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= d;
        byteenable_i <= be;
        write_i <= wr;
        read_i <= !wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 20);
        if (n >= 20) begin
            hung();
        end
        rd = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
    endtask
    // Capture one master frame, then wait for sync to return to its idle level
    task automatic frame(input logic pol, input logic inv, input logic [15:0] exp,
        input int ep);
        int n = 0;
        host_link_model_inst.master_read(pol, inv, w, per, ok);
        if (!ok) begin
            hung();
        end
        check(32'(w), 32'(exp));
        check(32'(per), 32'(ep));
        while (sync_o !== pol && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        check(32'(sync_o), 32'(pol));
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        repeat (12) @(posedge clk_i);
        check(32'(waitrequest_o), 32'h1);
        check(32'(data_oe_o), 32'h0);
        rst_n_i <= 1'b1;
        bus(1'b1, adc_port_pkg::REG_RESULT, 32'hA5C3, 4'h3);
        repeat (3) @(posedge clk_i);
        check(32'(data_oe_o), 32'hFFFF);
        check(32'(data_o), 32'hA5C3);
        bus(1'b1, 4'hC, 32'h1234, 4'hF);
        bus(1'b0, 4'hC, 32'h0, 4'hF);
        check(rd, 32'h0);
        bus(1'b0, adc_port_pkg::REG_RESULT, 32'h0, 4'hF);
        check(rd, 32'hA5C3);
        for (int i = 0; i < 4; i++) begin
            low_power_mode_i <= i[0];
            fast_mode_i <= i[1];
            repeat (3) @(posedge clk_i);
            check(32'(conv_mode_o), 32'(modes[i]));
        end
        host_link_model_inst.straps(2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        serial_parallel_select_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        check(32'(data_oe_o), 32'h0303);
        bus(1'b1, adc_port_pkg::REG_RESULT, 32'h9A6C, 4'h3);
        frame(1'b0, 1'b0, 16'h9A6C, 2 * (adc_port_pkg::SCLK_BASE_HALF << 1));
        host_link_model_inst.straps(2'h3, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        repeat (3) @(posedge clk_i);
        check(32'(data_oe_o[3:2]), 32'h0);
        bus(1'b1, adc_port_pkg::REG_RESULT, 32'h3C5A, 4'h3);
        repeat (6) @(posedge clk_i);
        check(32'(sync_o), 32'h1);
        bus(1'b1, adc_port_pkg::REG_CTRL, 32'h1, 4'h1);
        frame(1'b1, 1'b1, 16'h3C5A, 2 * adc_port_pkg::SCLK_BASE_HALF);
        for (int k = 0; k < 2; k++) begin
            host_link_model_inst.straps(2'h0, 1'b0, 1'b1, 1'b0, k[0], 1'b0);
            repeat (3) @(posedge clk_i);
            check(32'(data_oe_o), 32'h0103);
            bus(1'b1, adc_port_pkg::REG_RESULT, 32'(words[k]), 4'h3);
            host_link_model_inst.slave_read(k[0], 5, w);
            check(32'(w), 32'(words[k]));
            check(32'(sync_o), 32'h0);
        end
        results();
    end
endmodule
`default_nettype wire
